// *** rtl/pcc_clock_control.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcc_defs.svh"

// Notes on behaviour
// - PLL tracks 384 times the crystal
// - Core clock is full or binary submultiple
// - Reset core clock is PLL divided by 8
// - Modulator rate equals crystal, synchronous to core
// - Register at D7H, resets 03H, byte only
// - Bit 7 halts crystal during power-down
// - Bit 6 read-only lock indicator
// - Lock reads zero when not tracking
// - Bit 4 returns pin latched at reset
// - Fast option runs interrupts at full clock
// - Divider rate resumes after interrupt return
// - Bits 2:0 divide PLL by 2^n
module pcc_clock_control (
  // Clock and reset (clock is the PLL output)
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // Special-function register port
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic       i_sfr_wr_en,
  input  wire logic [7:0] i_sfr_wdata,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_hit,
  // Crystal, pins and core status
  input  wire logic       i_xtal_ref,
  input  wire logic       i_external_access_pin,
  input  wire logic       i_power_down,
  input  wire logic       i_irq_in_service,
  // Clock outputs
  output logic            o_core_tick,
  output logic      [2:0] o_core_divider_code,
  output logic            o_modulator_tick,
  output logic            o_pll_locked,
  output logic            o_xtal_osc_enable,
  output logic            o_interval_counter_run
);

  // ********************************************************
  // Declarations
  // ********************************************************
  pcc_div_if div_link ();

  logic                        crystal_halt_in_sleep_reg;
  logic                        crystal_halt_in_sleep_next;
  logic                        fast_irq_clock_select_reg;
  logic                        fast_irq_clock_select_next;
  logic [2:0]                  core_divider_code_reg;
  logic [2:0]                  core_divider_code_next;
  logic                        latched_ea_reg;
  logic                        latched_ea_next;
  logic                        ea_pending_reg;
  logic                        ea_pending_next;
  logic [7:0]                  rdata_reg;
  logic [7:0]                  rdata_next;
  logic                        osc_en_reg;
  logic                        osc_en_next;
  pcc_pkg::pcc_lock_state_type lock_state_reg;
  pcc_pkg::pcc_lock_state_type lock_state_next;
  logic [9:0]                  period_cnt_reg;
  logic [9:0]                  period_cnt_next;
  logic [2:0]                  good_cnt_reg;
  logic [2:0]                  good_cnt_next;
  logic                        ref_prev_reg;
  logic                        ref_prev_next;
  logic                        addr_hit;
  logic                        write_hit;
  logic                        ref_rise;
  logic                        period_good;
  logic                        timeout;
  logic                        locked;
  logic [9:0]                  period_len;
  logic [7:0]                  reg_image;

  // ********************************************************
  // Core divider
  // ********************************************************
  pcc_core_divider i_pcc_core_divider (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .div       (div_link.div)
  );

  // Fast interrupt forces code 0 while a handler runs, then falls back
  assign div_link.code_req = (fast_irq_clock_select_reg && i_irq_in_service) ?
                             3'h0 : core_divider_code_reg;

  // ********************************************************
  // Register port
  // ********************************************************
  // Byte address only; no bit-address alias exists for this register
  assign addr_hit  = (i_sfr_addr == `PCC_REG_ADDR);
  assign write_hit = addr_hit && i_sfr_wr_en;
  assign locked    = (lock_state_reg == pcc_pkg::pcc_st_locked);

  // Read image: lock bit is live, reserved bit reads zero
  always_comb begin
    reg_image                 = 8'h00;
    reg_image[`PCC_BIT_HALT]  = crystal_halt_in_sleep_reg;
    reg_image[`PCC_BIT_LOCK]  = locked;
    reg_image[`PCC_BIT_EA]    = latched_ea_reg;
    reg_image[`PCC_BIT_FAST]  = fast_irq_clock_select_reg;
    reg_image[2:0]            = core_divider_code_reg;
  end

  // Write fields; lock, reserved and latched pin bits ignore writes
  always_comb begin
    crystal_halt_in_sleep_next = crystal_halt_in_sleep_reg;
    fast_irq_clock_select_next = fast_irq_clock_select_reg;
    core_divider_code_next     = core_divider_code_reg;
    if (write_hit) begin
      crystal_halt_in_sleep_next = i_sfr_wdata[`PCC_BIT_HALT];
      fast_irq_clock_select_next = i_sfr_wdata[`PCC_BIT_FAST];
      core_divider_code_next     = i_sfr_wdata[2:0];
    end
    rdata_next = addr_hit ? reg_image : 8'h00;
  end

  // Pin level is caught by the first clock after reset release
  always_comb begin
    ea_pending_next = 1'b0;
    latched_ea_next = ea_pending_reg ? i_external_access_pin : latched_ea_reg;
  end

  // Crystal runs in power-down unless the halt bit is set
  always_comb begin
    osc_en_next = !(i_power_down && crystal_halt_in_sleep_reg);
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      crystal_halt_in_sleep_reg <= 1'(`PCC_REG_RESET >> `PCC_BIT_HALT);
      fast_irq_clock_select_reg <= 1'b0;
      core_divider_code_reg     <= `PCC_DIV_RESET;
      latched_ea_reg            <= 1'b0;
      ea_pending_reg            <= 1'b1;
      rdata_reg                 <= 8'h00;
      osc_en_reg                <= 1'b1;
    end else begin
      crystal_halt_in_sleep_reg <= crystal_halt_in_sleep_next;
      fast_irq_clock_select_reg <= fast_irq_clock_select_next;
      core_divider_code_reg     <= core_divider_code_next;
      latched_ea_reg            <= latched_ea_next;
      ea_pending_reg            <= ea_pending_next;
      rdata_reg                 <= rdata_next;
      osc_en_reg                <= osc_en_next;
    end
  end

  // ********************************************************
  // Lock tracker
  // ********************************************************
  // Measures PLL cycles per crystal period; a missing crystal times out
  assign ref_rise    = i_xtal_ref && !ref_prev_reg;
  assign period_len  = period_cnt_reg + 10'h001;
  assign period_good = (period_len >= `PCC_PLL_MULT - `PCC_LOCK_TOL) &&
                       (period_len <= `PCC_PLL_MULT + `PCC_LOCK_TOL);
  assign timeout     = (period_cnt_reg == `PCC_LOCK_TIMEOUT);

  always_comb begin
    ref_prev_next   = i_xtal_ref;
    period_cnt_next = ref_rise ? 10'h000 :
                      (timeout ? period_cnt_reg : period_cnt_reg + 10'h001);
    lock_state_next = lock_state_reg;
    good_cnt_next   = good_cnt_reg;
    if (!osc_en_reg || i_power_down) begin
      // PLL is off in power-down; software must wait for relock
      lock_state_next = pcc_pkg::pcc_st_unlocked;
      good_cnt_next   = 3'h0;
    end else begin
      case (lock_state_reg)
        pcc_pkg::pcc_st_unlocked: begin
          good_cnt_next = 3'h0;
          if (ref_rise) begin
            lock_state_next = pcc_pkg::pcc_st_acquire;
          end
        end
        pcc_pkg::pcc_st_acquire: begin
          if (timeout || (ref_rise && !period_good)) begin
            lock_state_next = pcc_pkg::pcc_st_unlocked;
          end else if (ref_rise) begin
            good_cnt_next = good_cnt_reg + 3'h1;
            if (good_cnt_reg == `PCC_LOCK_GOOD - 3'h1) begin
              lock_state_next = pcc_pkg::pcc_st_locked;
            end
          end
        end
        pcc_pkg::pcc_st_locked: begin
          if (timeout || (ref_rise && !period_good)) begin
            lock_state_next = pcc_pkg::pcc_st_unlocked;
            good_cnt_next   = 3'h0;
          end
        end
        default: begin
          lock_state_next = pcc_pkg::pcc_st_unlocked;
          good_cnt_next   = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lock_state_reg <= pcc_pkg::pcc_st_unlocked;
      period_cnt_reg <= 10'h000;
      good_cnt_reg   <= 3'h0;
      ref_prev_reg   <= 1'b0;
    end else begin
      lock_state_reg <= lock_state_next;
      period_cnt_reg <= period_cnt_next;
      good_cnt_reg   <= good_cnt_next;
      ref_prev_reg   <= ref_prev_next;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign o_sfr_rdata            = rdata_reg;
  assign o_sfr_hit              = addr_hit;
  assign o_core_tick            = div_link.tick;
  assign o_core_divider_code    = div_link.code_eff;
  assign o_modulator_tick       = div_link.mod_tick;
  assign o_pll_locked           = locked;
  assign o_xtal_osc_enable      = osc_en_reg;
  assign o_interval_counter_run = osc_en_reg;

  // ********************************************************
  // Checks
  // ********************************************************
  logic [8:0] mod_gap_reg;
  logic       mod_seen_reg;
  logic       first_reg;

  // Helper: cycles since the last modulator tick
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mod_gap_reg  <= 9'h000;
      mod_seen_reg <= 1'b0;
      first_reg    <= 1'b1;
    end else begin
      mod_gap_reg  <= div_link.mod_tick ? 9'h000 : mod_gap_reg + 9'h001;
      mod_seen_reg <= mod_seen_reg || div_link.mod_tick;
      first_reg    <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // A tick on the window boundary may be followed by a new code, so it is left out
  sequence s_div3_tick;
    div_link.tick && (div_link.code_eff == 3'h3) && !div_link.boundary;
  endsequence

  sequence s_div3_gap;
    !div_link.tick [*7] ##1 div_link.tick;
  endsequence

  a_mod_period: assert property (div_link.mod_tick && mod_seen_reg |-> mod_gap_reg == 9'h17F)
    else $error("modulator period is not 384 cycles");
  a_reset_image: assert property (first_reg |-> reg_image == `PCC_REG_RESET)
    else $error("register not at reset value after reset");
  a_div3_period: assert property (s_div3_tick |=> s_div3_gap)
    else $error("divide-by-8 period wrong");
  a_lock_read: assert property (addr_hit |=> o_sfr_rdata[`PCC_BIT_LOCK] == $past(locked))
    else $error("lock bit read does not match tracker");
  a_lock_loss: assert property (timeout && !ref_rise |=> !o_pll_locked)
    else $error("lock held without crystal edges");
  a_osc_halt: assert property (i_power_down && crystal_halt_in_sleep_reg |=> !o_xtal_osc_enable)
    else $error("crystal not halted in power-down");
  a_ea_hold: assert property (!ea_pending_reg |=> $stable(latched_ea_reg))
    else $error("latched pin bit changed after capture");
  a_rsvd_zero: assert property (addr_hit |=> o_sfr_rdata[`PCC_BIT_RSVD] == 1'b0)
    else $error("reserved bit reads one");
  a_fast_irq: assert property (div_link.boundary && fast_irq_clock_select_reg && i_irq_in_service
                               |=> o_core_divider_code == 3'h0)
    else $error("interrupt not served at full clock");
  a_irq_return: assert property (div_link.boundary && !i_irq_in_service
                                 |=> o_core_divider_code == $past(core_divider_code_reg))
    else $error("divider rate not resumed");

endmodule

`default_nettype wire

// *** rtl/pcc_core_divider.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcc_defs.svh"

module pcc_core_divider (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Divider link
  pcc_div_if.div   div
);

  logic [6:0] prescale_reg;
  logic [6:0] prescale_next;
  logic [2:0] code_eff_reg;
  logic [2:0] code_eff_next;
  logic [8:0] mod_cnt_reg;
  logic [8:0] mod_cnt_next;
  logic [6:0] mask;

  // ********************************************************
  // Next-state: prescaler, divider code, modulator counter
  // ********************************************************
  // Code only changes at the coarsest boundary, so no short period appears
  always_comb begin
    prescale_next = prescale_reg + 7'h01;
    code_eff_next = div.boundary ? div.code_req : code_eff_reg;
    mod_cnt_next  = (mod_cnt_reg == `PCC_MOD_LAST) ? 9'h000 : mod_cnt_reg + 9'h001;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      prescale_reg <= 7'h00;
      code_eff_reg <= `PCC_DIV_RESET;
      mod_cnt_reg  <= 9'h000;
    end else begin
      prescale_reg <= prescale_next;
      code_eff_reg <= code_eff_next;
      mod_cnt_reg  <= mod_cnt_next;
    end
  end

  // Outputs: tick closes each 2^n period
  assign mask          = pcc_pkg::pcc_div_mask(code_eff_reg);
  assign div.boundary  = (prescale_reg == `PCC_PRESCALE_LAST);
  assign div.tick      = ((prescale_reg & mask) == mask);
  assign div.code_eff  = code_eff_reg;
  assign div.mod_tick  = (mod_cnt_reg == `PCC_MOD_LAST);

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_mod_aligned: assert property (div.mod_tick |-> div.boundary && div.tick)
    else $error("modulator tick not aligned with core period");
  a_div_switch: assert property (!$stable(code_eff_reg) |-> $past(div.boundary))
    else $error("divider code changed inside a period");

endmodule

`default_nettype wire

// *** rtl/pcc_defs.svh ***
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

// ********************************************************
// Register location and layout
// ********************************************************
`define PCC_REG_ADDR        8'hD7
`define PCC_REG_RESET       8'h03
`define PCC_BIT_HALT        7
`define PCC_BIT_LOCK        6
`define PCC_BIT_RSVD        5
`define PCC_BIT_EA          4
`define PCC_BIT_FAST        3
`define PCC_DIV_RESET       3'h3

// ********************************************************
// Clocking and lock detection
// ********************************************************
`define PCC_XTAL_FREQ_HZ    32768
`define PCC_PLL_MULT        10'h180
`define PCC_MOD_LAST        9'h17F
`define PCC_LOCK_TOL        10'h004
`define PCC_LOCK_TIMEOUT    10'h300
`define PCC_LOCK_GOOD       3'h4
`define PCC_PRESCALE_LAST   7'h7F

`endif

// *** rtl/pcc_div_if.sv ***
`timescale 1ns/100ps
`default_nettype none

interface pcc_div_if;
  logic [2:0] code_req;
  logic [2:0] code_eff;
  logic       boundary;
  logic       tick;
  logic       mod_tick;

  modport ctl (output code_req, input code_eff, boundary, tick, mod_tick);
  modport div (input code_req, output code_eff, boundary, tick, mod_tick);
endinterface

`default_nettype wire

// *** rtl/pcc_pkg.sv ***
package pcc_pkg;

  // Lock tracker states, Gray along unlocked -> acquire -> locked
  typedef enum logic [1:0] {
    pcc_st_unlocked = 2'b00,
    pcc_st_acquire  = 2'b01,
    pcc_st_locked   = 2'b11
  } pcc_lock_state_type;

  // Low-bit mask of a divide-by-2^n period
  function automatic logic [6:0] pcc_div_mask(input logic [2:0] code);
    logic [7:0] full;
    full = (8'h01 << code) - 8'h01;
    return full[6:0];
  endfunction

endpackage

// *** testbench/pcc_xtal_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Watch crystal seen in the PLL clock domain
// ****************************************
module pcc_xtal_model (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Oscillator control
  input  wire logic i_enable,
  input  wire logic i_present,
  // Reference level
  output var logic  o_xtal_ref
);
  logic [8:0] cnt_reg;

  // One crystal period per 384 system clocks; a halted or missing crystal stands low
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg    <= 9'h000;
      o_xtal_ref <= 1'b0;
    end else if (!i_enable || !i_present) begin
      cnt_reg    <= 9'h000;
      o_xtal_ref <= 1'b0;
    end else begin
      cnt_reg    <= (cnt_reg == 9'h17F) ? 9'h000 : cnt_reg + 9'h001;
      o_xtal_ref <= (cnt_reg < 9'h0C0);
    end
  end
endmodule

`default_nettype wire

// *** testbench/test_pcc_clock_control.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pcc_defs.svh"

module test_pcc_clock_control;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst, wr_en, xref, ea_pin, pdown, irq, present;
  logic  [7:0] addr, wdata, rdata;
  logic        hit, tick, mtick, locked, osc_en, ic_run;
  logic  [2:0] code;
  logic  [7:0] d;
  logic [15:0] p;
  int          num_errors = 0;
  int          n_tests = 0;

  pcc_clock_control i_pcc_clock_control (
    .i_clk_sys(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr_en(wr_en),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_xtal_ref(xref),
    .i_external_access_pin(ea_pin), .i_power_down(pdown), .i_irq_in_service(irq),
    .o_core_tick(tick), .o_core_divider_code(code), .o_modulator_tick(mtick),
    .o_pll_locked(locked), .o_xtal_osc_enable(osc_en), .o_interval_counter_run(ic_run));

  pcc_xtal_model i_pcc_xtal_model (
    .i_clk_sys(clk), .i_rst(rst), .i_enable(osc_en), .i_present(present), .o_xtal_ref(xref));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Strobe is dropped one edge later so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data is registered, so it is taken one edge after the address lands
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    @(negedge clk);
    d = rdata;
  endtask

  // Cycles between two core ticks, sampled mid-cycle
  task automatic per();
    int n;
    @(negedge clk);
    for (n = 0; n < 400 && tick !== 1'b1; n++) @(negedge clk);
    p = 16'h0000;
    do begin
      @(negedge clk);
      p = p + 16'h0001;
    end while (tick !== 1'b1 && p < 16'h0190);
  endtask

  // Divider changes land only on the 128-cycle boundary
  task automatic wait_code(input logic [2:0] c);
    int n;
    for (n = 0; n < 300 && code !== c; n++) @(negedge clk);
    chk(16'(code), 16'(c));
  endtask

  task automatic wait_lock(input logic v, input int lim);
    int n;
    for (n = 0; n < lim && locked !== v; n++) @(negedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(`PCC_REG_ADDR);
    chk(16'(d), 16'h0013);
    chk(16'(hit), 16'h0001);
    chk(16'(code), 16'h0003);
    per();
    chk(p, 16'h0008);
    rd(8'hD6);
    chk(16'({hit, d}), 16'h0000);
  endtask

  task automatic t_lock();
    int n;
    wait_lock(1'b1, 3000);
    rd(`PCC_REG_ADDR);
    chk(16'(d), 16'h0053);
    wr(`PCC_REG_ADDR, 8'h43);
    rd(`PCC_REG_ADDR);
    chk(16'(d), 16'h0053);
    for (n = 0; n < 500 && mtick !== 1'b1; n++) @(negedge clk);
    chk(16'({mtick, tick}), 16'h0003);
    p = 16'h0000;
    do begin
      @(negedge clk);
      p = p + 16'h0001;
    end while (mtick !== 1'b1 && p < 16'h01F4);
    chk(p, 16'h0180);
  endtask

  task automatic t_divs();
    for (int c = 0; c < 8; c++) begin
      wr(`PCC_REG_ADDR, 8'(c));
      wait_code(3'(c));
      per();
      chk(p, 16'h0001 << c);
    end
  endtask

  task automatic t_fast();
    wr(`PCC_REG_ADDR, 8'h0D);
    wait_code(3'h5);
    @(posedge clk);
    irq <= 1'b1;
    wait_code(3'h0);
    per();
    chk(p, 16'h0001);
    @(posedge clk);
    irq <= 1'b0;
    wait_code(3'h5);
    per();
    chk(p, 16'h0020);
    wr(`PCC_REG_ADDR, 8'h05);
    irq <= 1'b1;
    repeat (300) @(negedge clk);
    chk(16'(code), 16'h0005);
    @(posedge clk);
    irq <= 1'b0;
  endtask

  task automatic t_pdown();
    int n;
    wr(`PCC_REG_ADDR, 8'h83);
    pdown <= 1'b1;
    repeat (4) @(negedge clk);
    chk(16'({osc_en, ic_run, locked}), 16'h0000);
    @(posedge clk);
    pdown <= 1'b0;
    d = 8'h00;
    // Software side: poll the lock bit after wake-up
    for (n = 0; n < 1200 && d[6] !== 1'b1; n++) rd(`PCC_REG_ADDR);
    chk(16'(d[6]), 16'h0001);
    wr(`PCC_REG_ADDR, 8'h03);
    pdown <= 1'b1;
    repeat (4) @(negedge clk);
    chk(16'({osc_en, ic_run, locked}), 16'h0006);
    @(posedge clk);
    pdown <= 1'b0;
    wait_lock(1'b1, 3000);
    chk(16'(locked), 16'h0001);
  endtask

  task automatic t_noxtal();
    @(posedge clk);
    present <= 1'b0;
    wait_lock(1'b0, 900);
    rd(`PCC_REG_ADDR);
    chk(16'({locked, d[6]}), 16'h0000);
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    rst     = 1'b1;
    addr    = 8'h00;
    wr_en   = 1'b0;
    wdata   = 8'h00;
    ea_pin  = 1'b1;
    pdown   = 1'b0;
    irq     = 1'b0;
    present = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    ea_pin <= 1'b0;                                                // Pin moves after capture
    t_reset();
    t_lock();
    t_divs();
    t_fast();
    t_pdown();
    t_noxtal();
    close_out();
  end
endmodule

`default_nettype wire
